// >>> rtl/ptt_timer.sv
`timescale 1ns/1ps

module ptt_timer import ptt_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // oscillator clock pin
    input wire logic osc_clock,
    // power mode and option inputs
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic stop_osc_keep_running,
    // register port
    input wire logic [PTT_ADDR_W-1:0] reg_addr,
    input wire logic [PTT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [PTT_DATA_W-1:0] reg_rdata,
    // interrupt and wake-up
    output logic tick_irq,
    output logic stop_wakeup
);

    // oscillator synchroniser and edge detector
    logic osc_sync1_reg;
    logic osc_sync2_reg;
    logic osc_prev_reg;
    logic osc_rise;

    // tick_control state
    logic tick_block_enable_reg;
    logic tick_block_enable_next;
    logic tick_irq_enable_reg;
    logic tick_irq_enable_next;
    logic [PTT_RATE_W-1:0] tick_rate_select_reg;
    logic [PTT_RATE_W-1:0] tick_rate_select_next;
    logic tick_pending_flag_reg;
    logic tick_pending_flag_next;

    // event status and mask
    logic [PTT_EVT_W-1:0] evt_status_reg;
    logic [PTT_EVT_W-1:0] evt_status_next;
    logic [PTT_EVT_W-1:0] evt_mask_reg;
    logic [PTT_EVT_W-1:0] evt_mask_next;
    logic [PTT_EVT_W-1:0] evt_set;

    // outputs
    logic irq_reg;
    logic irq_next;
    logic wake_reg;
    logic wake_next;
    logic [PTT_DATA_W-1:0] rdata_reg;
    logic [PTT_DATA_W-1:0] rdata_next;

    // internal strobes
    logic cpu_reach;
    logic wr_control;
    logic wr_status;
    logic wr_mask;
    logic ack_write;
    logic chain_runs;
    logic chain_step;
    logic rollover;
    logic [PTT_CHAIN_W-1:0] chain_count;

    // oscillator pin passes two flip-flops before the edge detector reads it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_sync1_reg <= 1'b0;
            osc_sync2_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_sync1_reg <= osc_clock;
            osc_sync2_reg <= osc_sync1_reg;
            osc_prev_reg <= osc_sync2_reg;
        end
    end

    // one-cycle enable per oscillator rising edge
    assign osc_rise = osc_sync2_reg & ~osc_prev_reg;

    // oscillator is gated off in stop mode unless the keep-running option is set
    assign chain_runs = ~stop_mode | stop_osc_keep_running;
    assign chain_step = osc_rise & chain_runs;

    // cpu accesses are dropped in wait and stop mode
    assign cpu_reach = ~wait_mode & ~stop_mode;
    assign wr_control = reg_wr & cpu_reach & (reg_addr == PTT_OFF_CONTROL);
    assign wr_status = reg_wr & cpu_reach & (reg_addr == PTT_OFF_EVT_STATUS);
    assign wr_mask = reg_wr & cpu_reach & (reg_addr == PTT_OFF_EVT_MASK);
    assign ack_write = wr_control & reg_wdata[PTT_BIT_ACK];

    // divider chain
    ptt_divider u_divider (
        .clk(clk),
        .sys_rst(sys_rst),
        .hold_zero(~tick_block_enable_reg),
        .step(chain_step),
        .rate_sel(tick_rate_select_reg),
        .count(chain_count),
        .rollover(rollover)
    );

    // tick_control next values
    always_comb begin
        tick_block_enable_next = tick_block_enable_reg;
        tick_irq_enable_next = tick_irq_enable_reg;
        tick_rate_select_next = tick_rate_select_reg;
        if (wr_control) begin
            tick_block_enable_next = reg_wdata[PTT_BIT_BLOCK_EN];
            tick_irq_enable_next = reg_wdata[PTT_BIT_IRQ_EN];
            tick_rate_select_next = reg_wdata[PTT_BIT_RATE_HI:PTT_BIT_RATE_LO];
        end
    end

    // pending flag: set by rollover, cleared only by acknowledge, set wins
    always_comb begin
        tick_pending_flag_next = tick_pending_flag_reg;
        if (ack_write) begin
            tick_pending_flag_next = 1'b0;
        end
        if (rollover) begin
            tick_pending_flag_next = 1'b1;
        end
    end

    // event sources: overrun and stop-mode wake-up
    always_comb begin
        evt_set = '0;
        evt_set[PTT_EVT_OVERRUN] = rollover & tick_pending_flag_reg & ~ack_write;
        evt_set[PTT_EVT_WAKE] = rollover & stop_mode & tick_irq_enable_reg;
    end

    // event status (write one to clear, set wins) and mask
    always_comb begin
        evt_status_next = evt_status_reg;
        evt_mask_next = evt_mask_reg;
        if (wr_status) begin
            evt_status_next = evt_status_reg & ~reg_wdata[PTT_EVT_W-1:0];
        end
        evt_status_next = evt_status_next | evt_set;
        if (wr_mask) begin
            evt_mask_next = reg_wdata[PTT_EVT_W-1:0];
        end
    end

    // interrupt and wake-up levels
    always_comb begin
        irq_next = (tick_pending_flag_next & tick_irq_enable_next)
            | (|(evt_status_next & evt_mask_next));
        wake_next = stop_mode & tick_pending_flag_next & tick_irq_enable_next;
    end

    // read data, valid in the cycle after the read strobe
    always_comb begin
        rdata_next = PTT_RDATA_RST;
        if (reg_rd && cpu_reach) begin
            unique case (reg_addr)
                PTT_OFF_CONTROL: begin
                    rdata_next[PTT_BIT_PENDING] = tick_pending_flag_reg;
                    rdata_next[PTT_BIT_RATE_HI:PTT_BIT_RATE_LO] = tick_rate_select_reg;
                    rdata_next[PTT_BIT_ACK] = 1'b0;
                    rdata_next[PTT_BIT_IRQ_EN] = tick_irq_enable_reg;
                    rdata_next[PTT_BIT_BLOCK_EN] = tick_block_enable_reg;
                end
                PTT_OFF_EVT_STATUS: begin
                    rdata_next[PTT_EVT_W-1:0] = evt_status_reg;
                end
                PTT_OFF_EVT_MASK: begin
                    rdata_next[PTT_EVT_W-1:0] = evt_mask_reg;
                end
                default: begin
                    rdata_next = PTT_RDATA_RST;
                end
            endcase
        end
    end

    // control and status registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_block_enable_reg <= PTT_BLOCK_EN_RST;
            tick_irq_enable_reg <= PTT_IRQ_EN_RST;
            tick_rate_select_reg <= PTT_RATE_RST;
            tick_pending_flag_reg <= PTT_PENDING_RST;
            evt_status_reg <= PTT_EVT_RST;
            evt_mask_reg <= PTT_EVT_RST;
        end else begin
            tick_block_enable_reg <= tick_block_enable_next;
            tick_irq_enable_reg <= tick_irq_enable_next;
            tick_rate_select_reg <= tick_rate_select_next;
            tick_pending_flag_reg <= tick_pending_flag_next;
            evt_status_reg <= evt_status_next;
            evt_mask_reg <= evt_mask_next;
        end
    end

    // output registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            rdata_reg <= PTT_RDATA_RST;
        end else begin
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            rdata_reg <= rdata_next;
        end
    end

    assign tick_irq = irq_reg;
    assign stop_wakeup = wake_reg;
    assign reg_rdata = rdata_reg;

endmodule

// >>> inc/ptt_pkg.sv
package ptt_pkg;

    // divider chain shape
    localparam int unsigned PTT_CHAIN_W = 18;
    localparam int unsigned PTT_TAP_N = 8;
    localparam int unsigned PTT_RATE_W = 3;
    // chain bit whose rise marks an event for rate code 0; each code step moves one bit down
    localparam int unsigned PTT_TAP_TOP = 17;

    // register port widths
    localparam int unsigned PTT_ADDR_W = 4;
    localparam int unsigned PTT_DATA_W = 8;

    // register offsets
    localparam logic [3:0] PTT_OFF_CONTROL = 4'h0;
    localparam logic [3:0] PTT_OFF_EVT_STATUS = 4'h1;
    localparam logic [3:0] PTT_OFF_EVT_MASK = 4'h2;

    // tick_control field positions
    localparam int unsigned PTT_BIT_BLOCK_EN = 1;
    localparam int unsigned PTT_BIT_IRQ_EN = 2;
    localparam int unsigned PTT_BIT_ACK = 3;
    localparam int unsigned PTT_BIT_RATE_LO = 4;
    localparam int unsigned PTT_BIT_RATE_HI = 6;
    localparam int unsigned PTT_BIT_PENDING = 7;

    // event status / mask field positions
    localparam int unsigned PTT_EVT_W = 2;
    localparam int unsigned PTT_EVT_OVERRUN = 0;
    localparam int unsigned PTT_EVT_WAKE = 1;

    // values after reset
    localparam logic PTT_BLOCK_EN_RST = 1'b0;
    localparam logic PTT_IRQ_EN_RST = 1'b0;
    localparam logic PTT_PENDING_RST = 1'b0;
    localparam logic [2:0] PTT_RATE_RST = 3'h0;
    localparam logic [1:0] PTT_EVT_RST = 2'h0;
    localparam logic [7:0] PTT_RDATA_RST = 8'h00;
    localparam logic [17:0] PTT_CHAIN_RST = 18'h00000;

    // chain increment
    localparam logic [17:0] PTT_CHAIN_ONE = 18'h00001;

endpackage

// >>> rtl/ptt_divider.sv
`timescale 1ns/1ps

module ptt_divider import ptt_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic hold_zero,
    input wire logic step,
    input wire logic [PTT_RATE_W-1:0] rate_sel,
    // results
    output logic [PTT_CHAIN_W-1:0] count,
    output logic rollover
);

    logic [PTT_CHAIN_W-1:0] chain_reg;
    logic [PTT_CHAIN_W-1:0] chain_next;
    logic roll_reg;
    logic roll_next;
    logic [PTT_TAP_N-1:0] tap_hit;

    // one detector per selectable tap: the next step drives this tap bit from 0 to 1
    generate
        for (genvar i = 0; i < PTT_TAP_N; i++) begin : g_tap
            localparam int unsigned K = PTT_TAP_TOP - i;
            assign tap_hit[i] = (chain_reg[K:0] == {1'b0, {K{1'b1}}});
        end
    endgenerate

    // chain next value and rollover pulse
    always_comb begin
        chain_next = chain_reg;
        roll_next = 1'b0;
        if (hold_zero) begin
            chain_next = PTT_CHAIN_RST;
        end else if (step) begin
            chain_next = chain_reg + PTT_CHAIN_ONE;
            roll_next = tap_hit[rate_sel];
        end
    end

    // chain registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chain_reg <= PTT_CHAIN_RST;
            roll_reg <= 1'b0;
        end else begin
            chain_reg <= chain_next;
            roll_reg <= roll_next;
        end
    end

    assign count = chain_reg;
    assign rollover = roll_reg;

endmodule

// >>> testbench/ptt_timer_asserts.sv
`timescale 1ns/1ps

module ptt_timer_asserts import ptt_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // power modes
    input wire logic wait_mode,
    input wire logic stop_mode,
    // register port
    input wire logic [PTT_ADDR_W-1:0] reg_addr,
    input wire logic [PTT_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [PTT_DATA_W-1:0] reg_rdata,
    // interrupt and wake-up
    input wire logic tick_irq,
    input wire logic stop_wakeup
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic seen_wr_reg;
    logic seen_wr_next;
    // remembers any write since reset
    always_comb begin
        seen_wr_next = seen_wr_reg | reg_wr;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            seen_wr_reg <= 1'b0;
        end else begin
            seen_wr_reg <= seen_wr_next;
        end
    end
    // control accesses that the block takes
    sequence s_wr_ctrl;
        reg_wr && !wait_mode && !stop_mode && reg_addr == PTT_OFF_CONTROL;
    endsequence
    sequence s_rd_ctrl;
        reg_rd && !wait_mode && !stop_mode && reg_addr == PTT_OFF_CONTROL;
    endsequence
    a_read_blocked: assert property (reg_rd && (wait_mode || stop_mode) |=> reg_rdata == 8'h00)
        else $error("read in low-power mode gave data");
    a_ack_reads_zero: assert property (s_rd_ctrl |=> !reg_rdata[PTT_BIT_ACK])
        else $error("acknowledge bit read as one");
    a_rate_readback: assert property (s_wr_ctrl ##1 s_rd_ctrl |=> reg_rdata[6:4] == $past(reg_wdata[6:4], 2))
        else $error("rate field lost");
    a_enable_readback: assert property (s_wr_ctrl ##1 s_rd_ctrl |=> reg_rdata[2:1] == $past(reg_wdata[2:1], 2))
        else $error("enable bits lost");
    a_irq_after_setup: assert property (tick_irq |-> seen_wr_reg)
        else $error("irq before any setup");
    a_wake_in_stop: assert property (stop_wakeup |-> $past(stop_mode))
        else $error("wake outside stop");
    a_wake_with_irq: assert property (stop_wakeup |-> tick_irq)
        else $error("wake without irq");
    a_wake_held: assert property (stop_wakeup && stop_mode |=> stop_wakeup)
        else $error("wake dropped in stop");
endmodule

// >>> testbench/periodic_tick_timer_tb_top.sv
`timescale 1ns/1ps

module periodic_tick_timer_tb_top import ptt_pkg::*;;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic osc_clock = 1'b0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic stop_osc_keep_running = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic tick_irq;
    logic stop_wakeup;
    int n_errors = 0;
    int checks_done = 0;
    int m_ctrl = 0;
    int m_stat = 0;
    int m_mask = 0;
    logic [31:0] lfsr = 32'h0001575A; // seed 87898

    ptt_timer i_ptt_timer (.clk(clk), .sys_rst(sys_rst), .osc_clock(osc_clock), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .stop_osc_keep_running(stop_osc_keep_running), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tick_irq(tick_irq), .stop_wakeup(stop_wakeup));

    // clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // write, then update the model when the block takes it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (!wait_mode && !stop_mode) begin
            if (a == PTT_OFF_CONTROL) m_ctrl = (d[PTT_BIT_ACK] ? 0 : m_ctrl & 8'h80) | (d & 8'h76);
            if (a == PTT_OFF_EVT_STATUS) m_stat = m_stat & ~d;
            if (a == PTT_OFF_EVT_MASK) m_mask = d & 8'h03;
        end
    endtask

    // read and compare with the model
    task automatic rd(input logic [3:0] a);
        int e;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        e = (wait_mode || stop_mode) ? 0 : a == PTT_OFF_CONTROL ? m_ctrl : a == PTT_OFF_EVT_STATUS ? m_stat :
            a == PTT_OFF_EVT_MASK ? m_mask : 0;
        @(negedge clk);
        chk(reg_rdata, e[7:0], "read");
        @(posedge clk);
    endtask

    task automatic chk_outs;
        @(negedge clk);
        chk({7'h00, tick_irq}, {7'h00, (m_ctrl[7] & m_ctrl[2]) | (|(m_stat & m_mask))}, "irq");
        chk({7'h00, stop_wakeup}, {7'h00, stop_mode & m_ctrl[7] & m_ctrl[2]}, "wake");
        @(posedge clk);
    endtask

    task automatic osc(input int n);
        repeat (n) begin
            osc_clock <= 1'b1;
            repeat (4) @(posedge clk);
            osc_clock <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // flag must stay clear until exactly the n-th oscillator edge
    task automatic event_at(input int n);
        osc(n - 1);
        chk_outs;
        osc(1);
        m_ctrl = m_ctrl | 8'h80;
        if (stop_mode && m_ctrl[2]) m_stat = m_stat | 2;
        chk_outs;
    endtask

    // acknowledge lands on the very edge at which the rollover from the n-th oscillator edge sets the flag
    task automatic event_ack_at(input int n);
        osc(n - 1);
        chk_outs;
        osc_clock <= 1'b1;
        repeat (3) @(posedge clk);
        wr(PTT_OFF_CONTROL, 8'h7E);
        m_ctrl = m_ctrl | 8'h80;
        osc_clock <= 1'b0;
        repeat (4) @(posedge clk);
        chk_outs;
    endtask

    // watchdog
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        $display("FAIL %0t watchdog expired", $time);
        give_verdict;
    end

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 4; a++) rd(a[3:0]);
        lfsr = nxt(lfsr);
        wr(4'hF, lfsr[7:0]);
        rd(4'hF);
        for (int c = 0; c < 8; c++) begin
            lfsr = nxt(lfsr);
            wr(PTT_OFF_CONTROL, {lfsr[7], c[2:0], lfsr[3:2], 1'b0, lfsr[0]});
            rd(PTT_OFF_CONTROL);
        end
        chk_outs;
        $display("done: reset and fields");
        wr(PTT_OFF_CONTROL, 8'h76);
        event_at(1024);
        wr(PTT_OFF_CONTROL, 8'hF6);
        rd(PTT_OFF_CONTROL);
        wait_mode <= 1'b1;
        wr(PTT_OFF_CONTROL, 8'h7E);
        rd(PTT_OFF_CONTROL);
        wait_mode <= 1'b0;
        rd(PTT_OFF_CONTROL);
        wr(PTT_OFF_CONTROL, 8'h7E);
        rd(PTT_OFF_CONTROL);
        chk_outs;
        $display("done: first event and acknowledge");
        wait_mode <= 1'b1;
        event_at(2048);
        wait_mode <= 1'b0;
        $display("done: full period in wait");
        wr(PTT_OFF_CONTROL, 8'h7E);
        stop_osc_keep_running <= 1'b1;
        stop_mode <= 1'b1;
        event_at(2048);
        stop_mode <= 1'b0;
        rd(PTT_OFF_EVT_STATUS);
        wr(PTT_OFF_CONTROL, 8'h7A);
        rd(PTT_OFF_CONTROL);
        chk_outs;
        wr(PTT_OFF_EVT_MASK, 8'h02);
        rd(PTT_OFF_EVT_MASK);
        chk_outs;
        wr(PTT_OFF_EVT_STATUS, 8'h02);
        rd(PTT_OFF_EVT_STATUS);
        chk_outs;
        $display("done: stop wake and event bits");
        wr(PTT_OFF_CONTROL, 8'h78);
        @(posedge clk);
        wr(PTT_OFF_CONTROL, 8'h76);
        stop_osc_keep_running <= 1'b0;
        stop_mode <= 1'b1;
        osc(600);
        chk_outs;
        stop_mode <= 1'b0;
        event_ack_at(1024);
        $display("done: stop without oscillator");
        wr(PTT_OFF_CONTROL, 8'h6C);
        @(posedge clk);
        wr(PTT_OFF_CONTROL, 8'h66);
        event_at(2048);
        $display("done: second rate");
        give_verdict;
    end
endmodule

bind ptt_timer ptt_timer_asserts i_ptt_timer_asserts (.clk(clk), .sys_rst(sys_rst), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tick_irq(tick_irq), .stop_wakeup(stop_wakeup));
